// file: hw/flash_apb_regs.sv
// APB slave holding controller registers.
// Assumes APB3 signalling, zero wait states, one clock.
`default_nettype none
module flash_apb_regs
  import flash_host_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_busy,
  input wire logic i_ready_busy_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] i_rdata,
  output logic [3:0] o_ctrl,
  output logic [flash_host_pkg::ADDR_W-1:0] o_addr,
  output logic [flash_host_pkg::DATA_W-1:0] o_wdata,
  output logic o_start_rd,
  output logic o_start_wr
);
  import flash_host_pkg::*;
  logic [3:0] ctrl_q, ctrl_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [31:0] rdata_q, rdata_d;
  logic acc, wr, hit;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) ||
      (a == OFS_CMD) || (a == OFS_STATUS) || (a == OFS_RDATA);
  endfunction

  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign hit = mapped(i_paddr);

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    o_start_rd = 1'b0;
    o_start_wr = 1'b0;
    rdata_d = 32'h0;
    if (wr && i_paddr == OFS_CTRL) begin
      ctrl_d = i_pwdata[3:0];
    end
    if (wr && i_paddr == OFS_ADDR) begin
      addr_d = i_pwdata[ADDR_W-1:0];
    end
    if (wr && i_paddr == OFS_WDATA) begin
      wdata_d = i_pwdata[DATA_W-1:0];
    end
    // Command ignored while a cycle is running
    if (wr && i_paddr == OFS_CMD && !i_busy) begin
      o_start_rd = i_pwdata[1:0] == CMD_READ;
      o_start_wr = i_pwdata[1:0] == CMD_WRITE;
    end
    unique case (i_paddr)
      OFS_CTRL: rdata_d = {28'h0, ctrl_q};
      OFS_ADDR: rdata_d = {12'h0, addr_q};
      OFS_WDATA: rdata_d = {16'h0, wdata_q};
      OFS_STATUS: rdata_d = {30'h0, i_ready_busy_n, i_busy};
      OFS_RDATA: rdata_d = {16'h0, i_rdata};
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign rdata_q = rdata_d;
  assign o_prdata = rdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit;
  assign o_ctrl = ctrl_q;
  assign o_addr = addr_q;
  assign o_wdata = wdata_q;
endmodule
`default_nettype wire

// file: hw/flash_bus_host.sv
// Host controller driving an asynchronous parallel NOR flash.
// Assumes device pins reach the board directly; APB from software.
`default_nettype none
module flash_bus_host
  import flash_host_pkg::*;
#(
  parameter int SETUP_CYC = flash_host_pkg::SETUP_CYCLES,
  parameter int STROBE_CYC = flash_host_pkg::STROBE_CYCLES,
  parameter int ACCESS_CYC = flash_host_pkg::ACCESS_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [flash_host_pkg::ADDR_W-2:0] o_addr,
  output logic o_chip_select_n,
  output logic o_output_gate_n,
  output logic o_write_strobe_n,
  output logic o_reset_n,
  output logic o_high_voltage_level,
  output logic o_write_protect_n,
  output logic o_width_select_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] i_data,
  output logic [flash_host_pkg::DATA_W-1:0] o_data,
  output logic [flash_host_pkg::DATA_W-1:0] o_data_oe,
  input wire logic i_ready_busy_n
);
  import flash_host_pkg::*;

  // ------------------------------------------------------------
  // Registers and synchronisers
  // ------------------------------------------------------------
  logic [3:0] ctrl;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic start_rd, start_wr, busy;
  logic [DATA_W:0] pin_sync;
  logic word_mode;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  flash_apb_regs u_regs (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_busy(busy),
    .i_ready_busy_n(pin_sync[DATA_W]),
    .i_rdata(rdata_q),
    .o_ctrl(ctrl),
    .o_addr(addr),
    .o_wdata(wdata),
    .o_start_rd(start_rd),
    .o_start_wr(start_wr)
  );

  // Data pins and ready_busy_n are asynchronous to i_mclk
  flash_pin_sync #(
    .W(DATA_W + 1)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_ready_busy_n, i_data}),
    .o_sync(pin_sync)
  );

  assign word_mode = ctrl[CTRL_WORD_BIT];

  // ------------------------------------------------------------
  // Bus cycle sequencer
  // ------------------------------------------------------------
  cyc_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic is_wr_q, is_wr_d;
  logic [ADDR_W-1:0] lat_addr_q, lat_addr_d;
  logic [DATA_W-1:0] lat_data_q, lat_data_d;
  logic cs_n_q, cs_n_d, og_n_q, og_n_d, ws_n_q, ws_n_d, drive_q, drive_d;

  assign busy = state_q != ST_IDLE;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    is_wr_d = is_wr_q;
    rdata_d = rdata_q;
    lat_addr_d = lat_addr_q;
    lat_data_d = lat_data_q;
    cs_n_d = cs_n_q;
    og_n_d = og_n_q;
    ws_n_d = ws_n_q;
    drive_d = drive_q;
    unique case (state_q)
      ST_IDLE: begin
        // Standby between cycles: no strobes, host not driving
        cs_n_d = 1'b1;
        og_n_d = 1'b1;
        ws_n_d = 1'b1;
        drive_d = 1'b0;
        // Device ignores cycles during reset; do not start one
        if ((start_rd || start_wr) && ctrl[CTRL_RST_BIT]) begin
          // One command is one bus cycle, read or write; short sequences cost less
          is_wr_d = start_wr;
          lat_addr_d = addr;
          lat_data_d = wdata;
          cs_n_d = 1'b0;
          drive_d = start_wr;
          cnt_d = CNT_W'(SETUP_CYC);
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          // Read: gate low, strobe high; write: strobe low, gate high
          og_n_d = is_wr_q;
          ws_n_d = !is_wr_q;
          cnt_d = is_wr_q ? CNT_W'(STROBE_CYC) : CNT_W'(ACCESS_CYC);
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          // Strobe rises first so data is latched while still driven
          ws_n_d = 1'b1;
          og_n_d = 1'b1;
          cnt_d = CNT_W'(SETUP_CYC);
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Sync delay is four cycles; sample after it settled
        if (cnt_q > CNT_W'(1)) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          if (!is_wr_q) begin
            // Byte mode returns only the low eight pins
            rdata_d = word_mode ? pin_sync[DATA_W-1:0] :
              {8'h00, pin_sync[7:0]};
          end
          cs_n_d = 1'b1;
          drive_d = 1'b0;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      is_wr_q <= 1'b0;
      rdata_q <= '0;
      lat_addr_q <= '0;
      lat_data_q <= '0;
      cs_n_q <= 1'b1;
      og_n_q <= 1'b1;
      ws_n_q <= 1'b1;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      is_wr_q <= is_wr_d;
      rdata_q <= rdata_d;
      lat_addr_q <= lat_addr_d;
      lat_data_q <= lat_data_d;
      cs_n_q <= cs_n_d;
      og_n_q <= og_n_d;
      ws_n_q <= ws_n_d;
      drive_q <= drive_d;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Address bus carries bits 18..0 in word mode, 19..1 in byte mode; bit 0 maps by mode.
  // Sector address is the upper bits, same in either mode.
  assign o_addr = word_mode ? lat_addr_q[ADDR_W-2:0] :
    lat_addr_q[ADDR_W-1:1];

  always_comb begin
    o_data = '0;
    o_data_oe = '0;
    if (word_mode) begin
      o_data = lat_data_q;
      o_data_oe = {DATA_W{drive_q}};
    end else begin
      // Top pin is the low address bit; bits 8..14 left floating
      o_data[7:0] = lat_data_q[7:0];
      o_data[DATA_W-1] = lat_addr_q[0];
      o_data_oe[7:0] = {8{drive_q}};
      o_data_oe[DATA_W-1] = !cs_n_q;
    end
  end

  assign o_chip_select_n = cs_n_q;
  assign o_output_gate_n = og_n_q;
  assign o_write_strobe_n = ws_n_q;
  assign o_reset_n = ctrl[CTRL_RST_BIT];
  // Protect cycles need the elevated level and write protect high
  assign o_high_voltage_level = ctrl[CTRL_HV_BIT];
  assign o_write_protect_n = ctrl[CTRL_WP_BIT];
  assign o_width_select_n = word_mode;
endmodule
`default_nettype wire

// file: hw/flash_host_pkg.sv
// Package for the parallel flash bus controller.
// Assumes a single 100 MHz clock and an APB register port.
`default_nettype none
package flash_host_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_TIME_NS = 70;
  localparam int ACCESS_CYCLES =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_TIME_NS = 40;
  localparam int STROBE_CYCLES =
    (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_TIME_NS = 10;
  localparam int SETUP_CYCLES =
    (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // CTRL fields
  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  localparam int CTRL_HV_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;

  // CMD codes
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------
  // Pin bundles
  // ------------------------------------------------------------
  typedef struct packed {
    logic chip_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic reset_n;
    logic high_voltage_level;
    logic write_protect_n;
    logic width_select_n;
  } ctl_pins_type;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
  } data_drive_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD = 5'h08,
    ST_DONE = 5'h10
  } cyc_state_type;
endpackage
`default_nettype wire

// file: hw/flash_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous inputs from the flash device.
`default_nettype none
module flash_pin_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    // Change accepted only when stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;
endmodule
`default_nettype wire

// file: tb/flash_bus_host_monitor.sv
// Checker for the flash host pin sequencing.
// Assumes it is bound onto flash_bus_host; one clock domain.
`default_nettype none
module flash_bus_host_monitor
  import flash_host_pkg::*;
#(
  parameter int SETUP_CYC = 1,
  parameter int STROBE_CYC = 4,
  parameter int ACCESS_CYC = 7
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [flash_host_pkg::ADDR_W-2:0] o_addr,
  input wire logic o_chip_select_n,
  input wire logic o_output_gate_n,
  input wire logic o_write_strobe_n,
  input wire logic o_reset_n,
  input wire logic o_width_select_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] o_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] og_cnt_q, og_cnt_d, ws_cnt_q, ws_cnt_d;
  // ----
  // Low-time counters, cleared while the strobe is high
  // ----
  always_comb begin
    og_cnt_d = o_output_gate_n ? 8'h00 : og_cnt_q + 8'h01;
    ws_cnt_d = o_write_strobe_n ? 8'h00 : ws_cnt_q + 8'h01;
  end
  always_ff @(posedge i_mclk) begin
    og_cnt_q <= i_sys_rst ? 8'h00 : og_cnt_d;
    ws_cnt_q <= i_sys_rst ? 8'h00 : ws_cnt_d;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ----
  // Pin relations
  // ----
  property p_rd_lv;
    !o_output_gate_n |-> !o_chip_select_n && o_write_strobe_n;
  endproperty
  a_rd_lv: assert property (p_rd_lv) else $error("bad read levels");
  property p_wr_lv;
    !o_write_strobe_n |-> !o_chip_select_n && o_output_gate_n;
  endproperty
  a_wr_lv: assert property (p_wr_lv) else $error("bad write levels");
  property p_rd_free;
    !o_output_gate_n |-> o_data_oe[14:0] == 15'h0000;
  endproperty
  a_rd_free: assert property (p_rd_free) else $error("drive in read");
  property p_byte_tri;
    !o_width_select_n |-> o_data_oe[14:8] == 7'h00;
  endproperty
  a_byte_tri: assert property (p_byte_tri) else $error("mid pins on");
  property p_byte_adr;
    !o_width_select_n && !o_chip_select_n |-> o_data_oe[15];
  endproperty
  a_byte_adr: assert property (p_byte_adr) else $error("top pin off");
  property p_acc;
    $rose(o_output_gate_n) |-> og_cnt_q == ACCESS_CYC;
  endproperty
  a_acc: assert property (p_acc) else $error("access length");
  property p_stb;
    $rose(o_write_strobe_n) |-> ws_cnt_q == STROBE_CYC;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe length");
  property p_setup;
    $fell(o_output_gate_n) || $fell(o_write_strobe_n)
      |-> !$past(o_chip_select_n, SETUP_CYC);
  endproperty
  a_setup: assert property (p_setup) else $error("no select setup");
  property p_adr_hold;
    !o_chip_select_n && !$past(o_chip_select_n) |-> $stable(o_addr);
  endproperty
  a_adr_hold: assert property (p_adr_hold) else $error("addr moved");
  property p_rst_idle;
    !o_reset_n |-> o_chip_select_n;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("access in reset");
endmodule
bind flash_bus_host flash_bus_host_monitor #(.SETUP_CYC(SETUP_CYC),
  .STROBE_CYC(STROBE_CYC), .ACCESS_CYC(ACCESS_CYC)) u_mon (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .o_addr(o_addr),
  .o_chip_select_n(o_chip_select_n), .o_output_gate_n(o_output_gate_n),
  .o_write_strobe_n(o_write_strobe_n), .o_reset_n(o_reset_n),
  .o_width_select_n(o_width_select_n), .o_data_oe(o_data_oe));
`default_nettype wire

// file: tb/flash_dev_model.sv
// Behavioural parallel flash: 64-word array, read and write cycles.
// Assumes the bench resolves the shared data pins.
`default_nettype none
module flash_dev_model (
  input wire logic [18:0] i_addr,
  input wire logic i_chip_select_n,
  input wire logic i_output_gate_n,
  input wire logic i_write_strobe_n,
  input wire logic i_reset_n,
  input wire logic i_write_protect_n,
  input wire logic i_width_select_n,
  input wire logic [15:0] i_bus,
  output logic [15:0] o_data,
  output logic [15:0] o_data_oe,
  output logic o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [6:0] adr_lat;
  logic wr_act, sel, wp_high;
  logic [15:0] w;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {8'h5A ^ 8'(i), 8'(i)};
    wr_act = 1'b0;
  end
  assign wp_high = (i_write_protect_n !== 1'b0);
  // Writes complete at once, so the model never reports busy
  assign o_ready_busy_n = 1'b1;
  always_comb begin
    w = mem[i_addr[5:0]];
    o_data = w;
    if (!i_width_select_n && i_bus[15]) o_data = {8'h00, w[15:8]};
    o_data_oe = 16'h0000;
    if (!i_chip_select_n && !i_output_gate_n && i_write_strobe_n &&
        i_reset_n) begin
      o_data_oe = i_width_select_n ? 16'hFFFF : 16'h00FF;
    end
  end
  // Address on the later fall, data on the earlier rise
  always @(i_chip_select_n or i_write_strobe_n or i_reset_n) begin
    sel = !i_chip_select_n && !i_write_strobe_n && i_output_gate_n &&
      i_reset_n;
    if (sel && !wr_act) begin
      adr_lat = {i_addr[5:0], i_bus[15]};
      wr_act = 1'b1;
    end else if (!sel && wr_act) begin
      wr_act = 1'b0;
      // Last word stands in for the outermost sector
      if (i_reset_n && (wp_high || adr_lat[6:1] != 6'h3F)) begin
        if (i_width_select_n) mem[adr_lat[6:1]] = i_bus;
        else if (adr_lat[0]) mem[adr_lat[6:1]][15:8] = i_bus[7:0];
        else mem[adr_lat[6:1]][7:0] = i_bus[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the flash bus host.
// Assumes the device model and the monitor bind are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, pslverr, err, rb_n;
  logic cs_n, og_n, ws_n, rst_n, hv, wp_n, wsel_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] addr;
  logic [15:0] h_d, h_oe, d_d, d_oe, bus, fill_q, p;
  int error_cnt, cmp_count;
  // Released pins show a pattern that flips every cycle
  assign bus = (h_oe & h_d) | (~h_oe & d_oe & d_d) | (~h_oe & ~d_oe & fill_q);
  flash_bus_host u_flash_bus_host (.i_mclk(clk), .i_sys_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_addr(addr), .o_chip_select_n(cs_n),
    .o_output_gate_n(og_n), .o_write_strobe_n(ws_n), .o_reset_n(rst_n),
    .o_high_voltage_level(hv), .o_write_protect_n(wp_n),
    .o_width_select_n(wsel_n), .i_data(bus), .o_data(h_d),
    .o_data_oe(h_oe), .i_ready_busy_n(rb_n));
  flash_dev_model u_flash_dev_model (.i_addr(addr), .i_chip_select_n(cs_n),
    .i_output_gate_n(og_n), .i_write_strobe_n(ws_n), .i_reset_n(rst_n),
    .i_write_protect_n(wp_n), .i_width_select_n(wsel_n), .i_bus(bus),
    .o_data(d_d), .o_data_oe(d_oe), .o_ready_busy_n(rb_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) fill_q <= ~fill_q;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task op(input logic [1:0] c);
    apb(1'b1, OFS_CMD, {30'h0, c});
    do apb(1'b0, OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task rd_at(input logic [19:0] a);
    apb(1'b1, OFS_ADDR, {12'h0, a});
    op(CMD_READ);
    apb(1'b0, OFS_RDATA, 32'h0);
  endtask
  task wr_at(input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, OFS_ADDR, {12'h0, a});
    apb(1'b1, OFS_WDATA, {16'h0, d});
    op(CMD_WRITE);
  endtask
  task t_reset;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {28'h0, CTRL_RESET});
    chk({31'h0, rst_n}, 32'h0);
    apb(1'b1, OFS_CMD, {30'h0, CMD_READ});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    chk({31'h0, cs_n}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask
  task t_pins;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFS_CTRL, c);
      @(negedge clk);
      chk({28'h0, hv, rst_n, wp_n, wsel_n}, c);
    end
  endtask
  task t_word;
    apb(1'b1, OFS_CTRL, 32'h7);
    rd_at(20'h5);
    chk(rd, 32'h5F05);
    wr_at(20'h3F, 16'hBEEF);
    rd_at(20'h3F);
    chk(rd, 32'hBEEF);
    apb(1'b1, OFS_CTRL, 32'h5);
    wr_at(20'h3F, 16'h1234);
    apb(1'b1, OFS_CTRL, 32'h7);
    rd_at(20'h3F);
    chk(rd, 32'hBEEF);
  endtask
  task t_byte;
    p = 16'h5309;
    apb(1'b1, OFS_CTRL, 32'h6);
    rd_at(20'h13);
    chk(rd, {24'h0, p[15:8]});
    wr_at(20'h12, 16'h0077);
    rd_at(20'h12);
    chk(rd, 32'h77);
    rd_at(20'h13);
    chk(rd, {24'h0, p[15:8]});
    apb(1'b1, OFS_CTRL, 32'h7);
    rd_at(20'h9);
    chk(rd, {16'h0, p[15:8], 8'h77});
  endtask
  task close_out;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; fill_q = 16'hA5A5; error_cnt = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pins();
    t_word();
    t_byte();
    close_out();
  end
  // Whole run needs well under a tenth of this span
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
